/* bench/tbd_beeper_bench.sv */
// Self-checking bench of the tone beeper driver
`timescale 1ns/10ps
module tbd_beeper_bench;
    localparam int STEP = 5000;
    logic        clock;
    logic        reset_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [31:0] rdat;
    logic        ack;
    logic        beep_p;
    logic        beep_n;
    logic        irq;
    logic        dc_seen;
    logic [31:0] q;
    logic [3:0]  acc;
    logic [3:0]  lanes;
    logic [7:0]  per;
    int          flips;
    int          half;
    int          n_errors;
    int          comparisons;
    int          seed;
    int          f0;
    longint      t0;

    tbd_beeper #(.STEP_CYCLES(STEP), .NEAR_PAIRS(2)) u_dut (
        .clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .beep_p(beep_p), .beep_n(beep_n),
        .irq(irq)
    );
    tbd_sounder u_snd (
        .clock(clock), .beep_p(beep_p), .beep_n(beep_n), .flips(flips),
        .half(half), .dc_seen(dc_seen)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_rng(input string what, input int lo, input int hi,
                             input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= lanes;
        do @(posedge clock); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Polls busy; reads clear events, so they are gathered as we go
    task automatic wait_idle();
        do begin
            xfer(1'b0, tbd_pkg::ADDR_STAT, 32'h0);
            acc = acc | q[3:0];
        end while (q[tbd_pkg::STAT_BUSY_BIT] !== 1'b0);
        xfer(1'b0, tbd_pkg::ADDR_STAT, 32'h0);
        acc = acc | q[3:0];
    endtask

    function automatic logic [3:0] model_ev(input int seq, input int pairs);
        model_ev = 4'h3;
        if (seq == 1 && pairs != 0) begin
            model_ev = 4'hF;
        end
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        // Tests need about 76000 cycles; the margin covers polling
        repeat (95000) @(posedge clock);
        n_errors++;
        wrap_up();
    end

    initial begin
        seed = 32'h9E4A2E30;
        n_errors = 0;
        comparisons = 0;
        acc = 4'h0;
        lanes = 4'hF;
        {cyc, stb, we, adr, wdat, sel} = '0;
        reset_n = 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        xfer(1'b0, tbd_pkg::ADDR_TONE_A, 32'h0);
        check("tone_a", {16'h0, tbd_pkg::TONE_RST}, q);
        xfer(1'b0, tbd_pkg::ADDR_MASK, 32'h0);
        check("mask", 32'h0, q);
        // Only byte lane 1 may change
        lanes = 4'h2;
        xfer(1'b1, tbd_pkg::ADDR_TONE_A, 32'hFFFF_FFFF);
        lanes = 4'hF;
        xfer(1'b0, tbd_pkg::ADDR_TONE_A, 32'h0);
        check("tone_lane", {16'h0, 8'hFF, tbd_pkg::TONE_RST[7:0]}, q);
        xfer(1'b1, 8'h14, $random(seed));
        xfer(1'b0, 8'h14, 32'h0);
        check("unmapped", 32'h0, q);
        xfer(1'b0, tbd_pkg::ADDR_STAT, 32'h0);
        check("stat", 32'h0, {23'h0, q[8:0]});
        $display("test registers done");
        // Single tone at the top frequency, two steps long
        xfer(1'b1, tbd_pkg::ADDR_TONE_A, 32'h0000_0204);
        xfer(1'b1, tbd_pkg::ADDR_MASK, 32'h0000_000F);
        f0 = flips;
        xfer(1'b1, tbd_pkg::ADDR_CTRL, 32'h0000_0001);
        t0 = $time;
        repeat (6) @(posedge clock);
        check("irq_on", 32'h1, {31'h0, irq});
        wait_idle();
        check_rng("single_len", 2 * STEP - 5, 2 * STEP + 40,
                  int'(($time - t0) / 25));
        check("single_ev", {28'h0, model_ev(0, 1)}, {28'h0, acc});
        check_rng("flips", 3, 5, flips - f0);
        check_rng("half", 2430, 2455, half);
        repeat (3) @(posedge clock);
        check("irq_off", 32'h0, {31'h0, irq});
        $display("test single done");
        // One pair is near at start; four pairs reach the near point at a pair start
        for (int n = 1; n <= 4; n += 3) begin
            per = 8'(4 + ($unsigned($random(seed)) % 124));
            xfer(1'b1, tbd_pkg::ADDR_TONE_B, {16'h0, 8'h01, per});
            xfer(1'b1, tbd_pkg::ADDR_TONE_A, 32'h0000_0104);
            acc = 4'h0;
            xfer(1'b1, tbd_pkg::ADDR_CTRL, {16'h0, 8'(n), 8'h03});
            t0 = $time;
            wait_idle();
            check_rng("seq_len", 2 * n * STEP - 5, 2 * n * STEP + 60,
                      int'(($time - t0) / 25));
            check("seq_ev", {28'h0, model_ev(1, n)}, {28'h0, acc});
            $display("test sequence %0d done", n);
        end
        // Endless run, masked, stopped by software
        xfer(1'b1, tbd_pkg::ADDR_MASK, 32'h0);
        acc = 4'h0;
        xfer(1'b1, tbd_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (3 * STEP) @(posedge clock);
        check("irq_masked", 32'h0, {31'h0, irq});
        xfer(1'b0, tbd_pkg::ADDR_STAT, 32'h0);
        acc = acc | q[3:0];
        check("busy", 32'h1, {31'h0, q[8]});
        check("left", 32'h0, {24'h0, q[23:16]});
        xfer(1'b0, tbd_pkg::ADDR_CTRL, 32'h0);
        check("ctrl", 32'h0000_0003, q);
        xfer(1'b1, tbd_pkg::ADDR_CTRL, 32'h0);
        wait_idle();
        check("endless_ev", {28'h0, model_ev(1, 0)}, {28'h0, acc});
        check("idle_pins", 32'h0, {30'h0, beep_p, beep_n});
        check("dc", 32'h0, {31'h0, dc_seen});
        $display("test endless done");
        wrap_up();
    end
endmodule

/* bench/tbd_beeper_checker.sv */
// Checker of bus, interrupt and sounder pin behaviour
`timescale 1ns/10ps
module tbd_beeper_checker #(
    parameter int unsigned STEP_CYCLES = tbd_pkg::STEP_CYC,
    parameter int unsigned NEAR_PAIRS  = tbd_pkg::NEAR_PAIRS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Pins
    input  wire logic        beep_p,
    input  wire logic        beep_n,
    input  wire logic        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Cycles since the wave last changed; the slowest tone bounds it
    logic        p_last_reg;
    logic [16:0] hold_reg;
    logic [16:0] hold_next;
    always_comb begin
        hold_next = hold_reg + 17'h1;
        if (beep_p == beep_n || beep_p != p_last_reg) begin
            hold_next = 17'h0;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_reg   <= 17'h0;
            p_last_reg <= 1'b0;
        end else begin
            hold_reg   <= hold_next;
            p_last_reg <= beep_p;
        end
    end

    sequence stop_write;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == tbd_pkg::ADDR_CTRL && !wb_dat_i[0];
    endsequence
    sequence mask_clear;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == tbd_pkg::ADDR_MASK && wb_dat_i[3:0] == 4'h0;
    endsequence
    sequence quiet_pins;
        !beep_p && !beep_n;
    endsequence

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without a request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i > tbd_pkg::ADDR_MASK |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    dat_hold_a: assert property (
        !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data changed without access");
    pair_compl_a: assert property (!(beep_p && beep_n))
        else $error("both sounder pins high");
    tone_bound_a: assert property (hold_reg < 17'h13200)
        else $error("half period longer than slowest tone");
    reset_idle_a: assert property ($rose(reset_n) |-> quiet_pins)
        else $error("pins not idle after reset");
    stop_idle_a: assert property (stop_write |-> ##[1:4] quiet_pins)
        else $error("pins not idle after stop");
    mask_quiet_a: assert property (mask_clear |-> ##[1:3] !irq)
        else $error("irq high with all events masked");
endmodule

bind tbd_beeper tbd_beeper_checker #(
    .STEP_CYCLES(STEP_CYCLES),
    .NEAR_PAIRS (NEAR_PAIRS)
) u_checker (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .beep_p(beep_p), .beep_n(beep_n), .irq(irq)
);

/* bench/tbd_sounder.sv */
// Piezo sounder model: passive, watches the differential drive
`timescale 1ns/10ps
module tbd_sounder (
    // Clock
    input  wire logic clock,
    // Terminals
    input  wire logic beep_p,
    input  wire logic beep_n,
    // Observations
    output int        flips,
    output int        half,
    output logic      dc_seen
);
    int run;
    int lvl;
    int prev;
    initial begin
        flips   = 0;
        half    = 0;
        dc_seen = 1'b0;
        run     = 0;
        prev    = 0;
    end
    always @(posedge clock) begin
        lvl = (beep_p && !beep_n) ? 1 : ((beep_n && !beep_p) ? -1 : 0);
        if (beep_p === 1'b1 && beep_n === 1'b1) begin
            dc_seen = 1'b1;
        end
        run = run + 1;
        if (lvl != prev) begin
            // Only a swing from one polarity to the other is a tone edge
            if (lvl != 0 && prev != 0) begin
                flips = flips + 1;
                half  = run;
            end
            run = 0;
        end
        prev = lvl;
    end
endmodule

/* core/tbd_beeper.sv */
// Beeper driver top: Wishbone registers, sequencer and outputs
`timescale 1ns/10ps
// Function
// - Drive two outputs as complementary pair forming differential tone.
// - Tone frequency programmable from 8 kHz down to about 0.25 kHz.
// - Tone logic runs from a fixed 32,768 Hz time base.
// - Tone duration 4 ms to 1.02 s in whole 4 ms steps.
// - Single mode plays one tone; multitone mode plays a sequence.
// - Sequence plays 1 to 254 tone pairs, then ends.
// - Endless sequence setting repeats pairs until software stops it.
// - Events for beep start, beep end, sequence end, sequence near end.
module tbd_beeper #(
    parameter int unsigned STEP_CYCLES = tbd_pkg::STEP_CYC,
    parameter int unsigned NEAR_PAIRS  = tbd_pkg::NEAR_PAIRS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Sounder terminals
    output logic             beep_p,
    output logic             beep_n,
    // Interrupt
    output logic             irq
);
    generate
        if (STEP_CYCLES < 1 || STEP_CYCLES > 24'hFFFFFF) begin : g_chk_step
            $error("STEP_CYCLES out of range");
        end
        if (NEAR_PAIRS > 253) begin : g_chk_near
            $error("NEAR_PAIRS out of range");
        end
    endgenerate

    localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);
    localparam logic [7:0]  NEAR_CNT  = 8'(NEAR_PAIRS + 1);

    // Bus decode
    logic        req;
    logic        done;
    logic        wr;
    logic        rd;
    logic [31:0] bmask;
    logic        ack_next;
    logic [31:0] rdat_next;

    // Registers
    logic        seq_reg;
    logic        seq_next;
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic [15:0] tone_a_reg;
    logic [15:0] tone_a_next;
    logic [15:0] tone_b_reg;
    logic [15:0] tone_b_next;
    logic [3:0]  mask_reg;
    logic [3:0]  mask_next;
    logic [3:0]  stat_reg;
    logic [3:0]  stat_next;

    // Time bases
    logic [25:0] acc_reg;
    logic [25:0] acc_next;
    logic [26:0] acc_sum;
    logic        ref_tick_reg;
    logic        ref_tick_next;
    logic [23:0] step_reg;
    logic [23:0] step_next;
    logic        step_tick;

    // Sequencer
    tbd_pkg::tbd_state_t state_reg;
    tbd_pkg::tbd_state_t state_next;
    logic [7:0]  dur_reg;
    logic [7:0]  dur_next;
    logic [7:0]  left_reg;
    logic [7:0]  left_next;
    logic        endless_reg;
    logic        endless_next;
    logic        near_reg;
    logic        near_next;
    logic        restart;
    logic [3:0]  ev;
    logic        start_req;
    logic        stop_req;
    logic [7:0]  dur_a;
    logic [7:0]  dur_b;
    logic [6:0]  period;
    logic        wave;
    logic        p_next;
    logic        n_next;

    always_comb begin
        req   = wb_cyc_i & wb_stb_i;
        // Writes and read side effects land on the edge that sees ack
        done  = req & wb_ack_o;
        wr    = done & wb_we_i;
        rd    = done & ~wb_we_i;
        bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        ack_next = req & ~wb_ack_o;
        case (wb_adr_i)
            tbd_pkg::ADDR_CTRL:   rdat_next = {16'h0000, cnt_reg, 6'h00,
                                    seq_reg, (state_reg != tbd_pkg::TBD_IDLE)};
            tbd_pkg::ADDR_TONE_A: rdat_next = {16'h0000, tone_a_reg};
            tbd_pkg::ADDR_TONE_B: rdat_next = {16'h0000, tone_b_reg};
            tbd_pkg::ADDR_STAT:   rdat_next = {8'h00, left_reg, 7'h00,
                                    (state_reg != tbd_pkg::TBD_IDLE),
                                    4'h0, stat_reg};
            tbd_pkg::ADDR_MASK:   rdat_next = {28'h0000000, mask_reg};
            default:              rdat_next = 32'h00000000;
        endcase
        if (!ack_next) begin
            rdat_next = wb_dat_o;
        end
    end

    always_comb begin
        seq_next    = seq_reg;
        cnt_next    = cnt_reg;
        tone_a_next = tone_a_reg;
        tone_b_next = tone_b_reg;
        mask_next   = mask_reg;
        start_req   = 1'b0;
        stop_req    = 1'b0;
        if (wr) begin
            case (wb_adr_i)
                tbd_pkg::ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        seq_next  = wb_dat_i[tbd_pkg::CTRL_SEQ_BIT];
                        start_req = wb_dat_i[tbd_pkg::CTRL_RUN_BIT];
                        stop_req  = ~wb_dat_i[tbd_pkg::CTRL_RUN_BIT];
                    end
                    if (wb_sel_i[1]) begin
                        cnt_next = wb_dat_i[tbd_pkg::CTRL_CNT_LSB +: 8];
                    end
                end
                tbd_pkg::ADDR_TONE_A: tone_a_next =
                    (tone_a_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
                tbd_pkg::ADDR_TONE_B: tone_b_next =
                    (tone_b_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
                tbd_pkg::ADDR_MASK: begin
                    if (wb_sel_i[0]) begin
                        mask_next = wb_dat_i[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        // Fractional divider keeps the 32,768 Hz average exact
        acc_sum = {1'b0, acc_reg} + {1'b0, tbd_pkg::REF_HZ_W};
        if (acc_sum >= {1'b0, tbd_pkg::CLK_HZ_W}) begin
            acc_next      = 26'(acc_sum - {1'b0, tbd_pkg::CLK_HZ_W});
            ref_tick_next = 1'b1;
        end else begin
            acc_next      = acc_sum[25:0];
            ref_tick_next = 1'b0;
        end
        step_tick = (step_reg == STEP_LAST);
        step_next = (restart | step_tick) ? 24'h000000 : step_reg + 24'h000001;
    end

    always_comb begin
        dur_a        = (tone_a_reg[tbd_pkg::TONE_DUR_LSB +: 8] == 8'h00) ?
                       8'h01 : tone_a_reg[tbd_pkg::TONE_DUR_LSB +: 8];
        dur_b        = (tone_b_reg[tbd_pkg::TONE_DUR_LSB +: 8] == 8'h00) ?
                       8'h01 : tone_b_reg[tbd_pkg::TONE_DUR_LSB +: 8];
        state_next   = state_reg;
        dur_next     = dur_reg;
        left_next    = left_reg;
        endless_next = endless_reg;
        near_next    = near_reg;
        restart      = 1'b0;
        ev           = 4'h0;
        case (state_reg)
            tbd_pkg::TBD_IDLE: begin
                if (start_req) begin
                    state_next = tbd_pkg::TBD_TONE_A;
                    dur_next   = dur_a;
                    restart    = 1'b1;
                    ev[tbd_pkg::EV_START] = 1'b1;
                    near_next  = 1'b0;
                    if (seq_next) begin
                        endless_next = (cnt_next == tbd_pkg::PAIRS_ENDLESS);
                        left_next = (cnt_next > tbd_pkg::PAIRS_MAX) ?
                                    tbd_pkg::PAIRS_MAX : cnt_next;
                        if (cnt_next != tbd_pkg::PAIRS_ENDLESS &&
                            cnt_next <= NEAR_CNT) begin
                            near_next = 1'b1;
                            ev[tbd_pkg::EV_SEQ_NEAR] = 1'b1;
                        end
                    end else begin
                        endless_next = 1'b0;
                        left_next    = 8'h00;
                    end
                end
            end
            tbd_pkg::TBD_TONE_A, tbd_pkg::TBD_TONE_B: begin
                if (stop_req) begin
                    state_next = tbd_pkg::TBD_IDLE;
                    left_next  = 8'h00;
                    ev[tbd_pkg::EV_END] = 1'b1;
                end else if (step_tick) begin
                    dur_next = dur_reg - 8'h01;
                    if (dur_reg == 8'h01) begin
                        ev[tbd_pkg::EV_END] = 1'b1;
                        restart = 1'b1;
                        if (!seq_reg) begin
                            state_next = tbd_pkg::TBD_IDLE;
                        end else if (state_reg == tbd_pkg::TBD_TONE_A) begin
                            state_next = tbd_pkg::TBD_TONE_B;
                            dur_next   = dur_b;
                            ev[tbd_pkg::EV_START] = 1'b1;
                        end else if (!endless_reg && left_reg <= 8'h01) begin
                            state_next = tbd_pkg::TBD_IDLE;
                            left_next  = 8'h00;
                            ev[tbd_pkg::EV_SEQ_END] = 1'b1;
                        end else begin
                            state_next = tbd_pkg::TBD_TONE_A;
                            dur_next   = dur_a;
                            ev[tbd_pkg::EV_START] = 1'b1;
                            if (!endless_reg) begin
                                left_next = left_reg - 8'h01;
                                if (!near_reg && left_next <= NEAR_CNT) begin
                                    near_next = 1'b1;
                                    ev[tbd_pkg::EV_SEQ_NEAR] = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            default: begin
                state_next = tbd_pkg::TBD_IDLE;
            end
        endcase
        period = (state_next == tbd_pkg::TBD_TONE_B) ?
                 tone_b_reg[tbd_pkg::TONE_PER_LSB +: 7] :
                 tone_a_reg[tbd_pkg::TONE_PER_LSB +: 7];
    end

    always_comb begin
        // New events beat a read clear in the same cycle
        stat_next = ((rd && wb_adr_i == tbd_pkg::ADDR_STAT) ? 4'h0 : stat_reg)
                    | ev;
        // Equal levels when silent leave no DC across the sounder
        if (state_reg == tbd_pkg::TBD_IDLE) begin
            p_next = 1'b0;
            n_next = 1'b0;
        end else begin
            p_next = wave;
            n_next = ~wave;
        end
    end

    tbd_tone u_tone (
        .clock   (clock),
        .reset_n (reset_n),
        .tick    (ref_tick_reg),
        .restart (restart),
        .period  (period),
        .wave    (wave)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h00000000;
            seq_reg      <= 1'b0;
            cnt_reg      <= 8'h01;
            tone_a_reg   <= tbd_pkg::TONE_RST;
            tone_b_reg   <= tbd_pkg::TONE_RST;
            mask_reg     <= tbd_pkg::MASK_RST;
            stat_reg     <= 4'h0;
            acc_reg      <= 26'h0000000;
            ref_tick_reg <= 1'b0;
            step_reg     <= 24'h000000;
            state_reg    <= tbd_pkg::TBD_IDLE;
            dur_reg      <= 8'h00;
            left_reg     <= 8'h00;
            endless_reg  <= 1'b0;
            near_reg     <= 1'b0;
            beep_p       <= 1'b0;
            beep_n       <= 1'b0;
            irq          <= 1'b0;
        end else begin
            wb_ack_o     <= ack_next;
            wb_dat_o     <= rdat_next;
            seq_reg      <= seq_next;
            cnt_reg      <= cnt_next;
            tone_a_reg   <= tone_a_next;
            tone_b_reg   <= tone_b_next;
            mask_reg     <= mask_next;
            stat_reg     <= stat_next;
            acc_reg      <= acc_next;
            ref_tick_reg <= ref_tick_next;
            step_reg     <= step_next;
            state_reg    <= state_next;
            dur_reg      <= dur_next;
            left_reg     <= left_next;
            endless_reg  <= endless_next;
            near_reg     <= near_next;
            beep_p       <= p_next;
            beep_n       <= n_next;
            irq          <= |(stat_next & mask_next);
        end
    end
endmodule

/* core/tbd_pkg.sv */
// Package: constants and types of the tone beeper driver
package tbd_pkg;

    // Clock rates
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned REF_HZ     = 32_768;
    localparam logic [25:0] CLK_HZ_W   = 26'(CLK_HZ);
    localparam logic [25:0] REF_HZ_W   = 26'(REF_HZ);

    // Duration step of 4 ms, counted in system clock cycles
    localparam int unsigned STEP_NS    = 4_000_000;
    localparam int unsigned CLK_PER_NS = 25;
    localparam int unsigned STEP_CYC   = STEP_NS / CLK_PER_NS;

    // Tone period in reference ticks: 4 gives 8 kHz, 127 about 0.25 kHz
    localparam logic [6:0]  PERIOD_MIN = 7'h04;

    // Pair count: 0 plays forever, largest finite count is 254
    localparam logic [7:0]  PAIRS_ENDLESS = 8'h00;
    localparam logic [7:0]  PAIRS_MAX     = 8'hFE;
    localparam int unsigned NEAR_PAIRS    = 2;

    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_TONE_A = 8'h04;
    localparam logic [7:0]  ADDR_TONE_B = 8'h08;
    localparam logic [7:0]  ADDR_STAT   = 8'h0C;
    localparam logic [7:0]  ADDR_MASK   = 8'h10;

    // Control fields
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned CTRL_SEQ_BIT  = 1;
    localparam int unsigned CTRL_CNT_LSB  = 8;

    // Tone fields
    localparam int unsigned TONE_PER_LSB  = 0;
    localparam int unsigned TONE_DUR_LSB  = 8;

    // Status fields
    localparam int unsigned EV_START      = 0;
    localparam int unsigned EV_END        = 1;
    localparam int unsigned EV_SEQ_END    = 2;
    localparam int unsigned EV_SEQ_NEAR   = 3;
    localparam int unsigned EV_W          = 4;
    localparam int unsigned STAT_BUSY_BIT = 8;
    localparam int unsigned STAT_LEFT_LSB = 16;

    // Reset values
    localparam logic [15:0] TONE_RST = 16'h0110;
    localparam logic [3:0]  MASK_RST = 4'h0;

    typedef enum logic [1:0] {
        TBD_IDLE,
        TBD_TONE_A,
        TBD_TONE_B
    } tbd_state_t;

endpackage

/* core/tbd_tone.sv */
// Square wave generator counting reference ticks
`timescale 1ns/10ps
module tbd_tone (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Control
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic [6:0] period,
    // Wave
    output logic            wave
);
    logic [6:0] per;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic       wave_next;

    always_comb begin
        // Short periods would exceed 8 kHz, so clamp them
        per = (period < tbd_pkg::PERIOD_MIN) ? tbd_pkg::PERIOD_MIN : period;
        cnt_next = cnt_reg;
        if (restart) begin
            cnt_next = 7'h00;
        end else if (tick) begin
            cnt_next = (cnt_reg >= per - 7'h01) ? 7'h00 : cnt_reg + 7'h01;
        end
        wave_next = (cnt_next < (per >> 1));
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 7'h00;
            wave    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            wave    <= wave_next;
        end
    end
endmodule
